/* File: logic/vm2_pkg.sv */
// Purpose : shared constants and types for the monitor-2 control block
// Assumes : 100 MHz bus clock, Avalon-MM 32-bit register port
// Notes   : offsets are byte addresses of aligned words
package vm2_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] VM2_OFS_LEVEL = 4'h0; // level_select_reg
  localparam logic [3:0] VM2_OFS_CMP   = 4'h4; // comparator_ctrl_reg
  localparam logic [3:0] VM2_OFS_CTRL0 = 4'h8; // mon2_ctrl0_reg
  localparam logic [3:0] VM2_OFS_CTRL1 = 4'hc; // mon2_ctrl1_reg
  localparam logic [3:0] VM2_OFS_STAT  = 4'h0; // mon2_status_reg, hi page
  localparam logic       VM2_PAGE_STAT = 1'b1; // address bit 4 selects status

  // field positions
  localparam int VM2_B_LVL      = 0; // level [1:0]
  localparam int VM2_B_SRC      = 0; // comparator_ctrl: input source
  localparam int VM2_B_CEN      = 1; // comparator_ctrl: circuit enable
  localparam int VM2_B_RIE      = 0; // ctrl0: irq/rst enable
  localparam int VM2_B_CMPE     = 2; // ctrl0: compare output enable
  localparam int VM2_B_RI       = 6; // ctrl0: irq or reset select
  localparam int VM2_B_RN       = 7; // ctrl0: reset release select
  localparam int VM2_B_EDGE     = 0; // ctrl1: edge select [1:0]
  localparam int VM2_B_TYPE     = 2; // ctrl1: irq type select
  localparam int VM2_B_FLAG     = 0; // status: crossing flag
  localparam int VM2_B_MON      = 1; // status: level flag

  // edge select codes
  localparam logic [1:0] VM2_EDGE_RISE = 2'h0;
  localparam logic [1:0] VM2_EDGE_FALL = 2'h1;
  localparam logic [1:0] VM2_EDGE_BOTH = 2'h2;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int VM2_CLK_MHZ           = 100;
  localparam int VM2_RST_DELAY_US      = 100; // rst_release_delay default
  localparam int VM2_RST_DELAY_CYC     = VM2_RST_DELAY_US * VM2_CLK_MHZ;
  localparam int VM2_CNT_W             = 24;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] level_sel;
    logic       input_src_sel;
    logic       circuit_en;
    logic       irq_rst_en;
    logic       cmp_out_en;
    logic       irq_or_rst_sel;
    logic       rst_release_sel;
    logic [1:0] edge_sel;
    logic       irq_type_sel;
  } vm2_cfg_t;

  localparam vm2_cfg_t VM2_CFG_RST = '0;

  typedef enum logic [1:0] {
    VM2_RUN  = 2'h0,
    VM2_HOLD = 2'h1,
    VM2_WAIT = 2'h3
  } vm2_rst_state_t;

endpackage

/* File: logic/vm2_ctrl.sv */
// Purpose : control logic of voltage monitoring channel 2
// Assumes : comparator output synchronous to ref_clk_in
// Notes   : registers reached over Avalon-MM, one wait state on reads
//
// What this block does
// - source select 0 compares the supply, 1 compares the external pin.
// - irq-or-reset select 0 means interrupt, 1 means reset.
// - reset release behaviour is chosen with the reset select.
// - writing 0 to the crossing flag clears it.
// - edge codes 00 rise, 01 fall, 10 both; 11 is prohibited, no detect.
// - reset releases a fixed delay after rise (0) or after assertion (1).
`timescale 1ns/1ps
`default_nettype none
module vm2_ctrl #(
  parameter int RST_DELAY_CYC = vm2_pkg::VM2_RST_DELAY_CYC
) (
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // avalon-mm slave
  input  wire logic [4:0]                 avs_address_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [31:0]                avs_writedata_in,
  output logic      [31:0]                avs_readdata_out,
  output logic                            avs_waitrequest_out,
  // analog comparator side
  input  wire logic                       cmp_above_in,
  output logic      [1:0]                 mon2_level_sel_out,
  output logic                            mon2_input_src_sel_out,
  output logic                            mon2_circuit_en_out,
  // system side
  output logic                            irq_maskable_out,
  output logic                            irq_nmi_out,
  output logic                            event_out,
  output logic                            mon_rst_out
);
  import vm2_pkg::*;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  vm2_cfg_t       cfg_r,   cfg_nxt;
  logic           flag_r,  flag_nxt;
  logic           prev_r,  prev_nxt;
  logic           rd_r,    rd_nxt;
  logic [31:0]    rdata_r, rdata_nxt;
  logic           irqm_r,  irqm_nxt;
  logic           nmi_r,   nmi_nxt;
  logic           evt_r,   evt_nxt;
  vm2_rst_state_t st_r,    st_nxt;
  logic [VM2_CNT_W-1:0] cnt_r, cnt_nxt;
  logic           rst_r,   rst_nxt;

  logic rise, fall, hit, wr_go, rd_go;

  // edge qualification per select code
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic r, input logic f);
    unique case (sel)
      VM2_EDGE_RISE: edge_hit = r;
      VM2_EDGE_FALL: edge_hit = f;
      VM2_EDGE_BOTH: edge_hit = r | f;
      default:       edge_hit = 1'b0;
    endcase
  endfunction

  // crossing detection, gated by compare output enable
  always_comb begin
    rise  = cfg_r.cmp_out_en & cmp_above_in & ~prev_r;
    fall  = cfg_r.cmp_out_en & ~cmp_above_in & prev_r;
    hit   = edge_hit(cfg_r.edge_sel, rise, fall);
    wr_go = avs_write_in;
    rd_go = avs_read_in & rd_r;
  end

  // ---------------------------------------------------------------------
  // register file and flag
  // ---------------------------------------------------------------------
  always_comb begin
    cfg_nxt   = cfg_r;
    flag_nxt  = flag_r;
    // always track, so enabling the compare output sees no stale edge
    prev_nxt  = cmp_above_in;
    rd_nxt    = avs_read_in & ~rd_r;
    rdata_nxt = '0;
    if (wr_go && avs_address_in[4] != VM2_PAGE_STAT) begin
      unique case (avs_address_in[3:0])
        VM2_OFS_LEVEL:
          cfg_nxt.level_sel = avs_writedata_in[VM2_B_LVL+:2];
        VM2_OFS_CMP: begin
          cfg_nxt.input_src_sel = avs_writedata_in[VM2_B_SRC];
          cfg_nxt.circuit_en    = avs_writedata_in[VM2_B_CEN];
        end
        VM2_OFS_CTRL0: begin
          cfg_nxt.irq_rst_en      = avs_writedata_in[VM2_B_RIE];
          cfg_nxt.cmp_out_en      = avs_writedata_in[VM2_B_CMPE];
          cfg_nxt.irq_or_rst_sel  = avs_writedata_in[VM2_B_RI];
          cfg_nxt.rst_release_sel = avs_writedata_in[VM2_B_RN];
        end
        VM2_OFS_CTRL1: begin
          cfg_nxt.edge_sel     = avs_writedata_in[VM2_B_EDGE+:2];
          cfg_nxt.irq_type_sel = avs_writedata_in[VM2_B_TYPE];
        end
        default: ;
      endcase
    end
    // write of 0 clears the flag; a crossing in that cycle wins
    if (wr_go && avs_address_in[4] == VM2_PAGE_STAT &&
        avs_address_in[3:0] == VM2_OFS_STAT &&
        !avs_writedata_in[VM2_B_FLAG])
      flag_nxt = 1'b0;
    if (hit)
      flag_nxt = 1'b1;
    if (avs_read_in && !rd_r) begin
      if (avs_address_in[4] == VM2_PAGE_STAT) begin
        if (avs_address_in[3:0] == VM2_OFS_STAT) begin
          rdata_nxt[VM2_B_FLAG] = flag_r;
          rdata_nxt[VM2_B_MON]  = ~cfg_r.cmp_out_en | cmp_above_in;
        end
      end else begin
        unique case (avs_address_in[3:0])
          VM2_OFS_LEVEL: rdata_nxt[VM2_B_LVL+:2] = cfg_r.level_sel;
          VM2_OFS_CMP: begin
            rdata_nxt[VM2_B_SRC] = cfg_r.input_src_sel;
            rdata_nxt[VM2_B_CEN] = cfg_r.circuit_en;
          end
          VM2_OFS_CTRL0: begin
            rdata_nxt[VM2_B_RIE]  = cfg_r.irq_rst_en;
            rdata_nxt[VM2_B_CMPE] = cfg_r.cmp_out_en;
            rdata_nxt[VM2_B_RI]   = cfg_r.irq_or_rst_sel;
            rdata_nxt[VM2_B_RN]   = cfg_r.rst_release_sel;
          end
          VM2_OFS_CTRL1: begin
            rdata_nxt[VM2_B_EDGE+:2] = cfg_r.edge_sel;
            rdata_nxt[VM2_B_TYPE]    = cfg_r.irq_type_sel;
          end
          default: ;
        endcase
      end
    end else if (rd_go) begin
      rdata_nxt = rdata_r;                   // hold for the taking edge
    end
  end

  // ---------------------------------------------------------------------
  // interrupt, event and reset sequencing
  // ---------------------------------------------------------------------
  always_comb begin
    logic act;
    act      = hit & cfg_r.irq_rst_en;
    evt_nxt  = hit;
    irqm_nxt = act & ~cfg_r.irq_or_rst_sel & ~cfg_r.irq_type_sel;
    nmi_nxt  = act & ~cfg_r.irq_or_rst_sel &  cfg_r.irq_type_sel;
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    unique case (st_r)
      VM2_RUN: begin
        // reset whenever the input is below the threshold (level, not edge)
        if (cfg_r.irq_rst_en && cfg_r.irq_or_rst_sel &&
            cfg_r.cmp_out_en && !cmp_above_in) begin
          st_nxt  = cfg_r.rst_release_sel ? VM2_WAIT : VM2_HOLD;
          cnt_nxt = '0;
        end
      end
      VM2_HOLD: begin
        cnt_nxt = '0;
        if (cmp_above_in)
          st_nxt = VM2_WAIT;
      end
      VM2_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!cfg_r.rst_release_sel && !cmp_above_in) begin
          st_nxt  = VM2_HOLD;
          cnt_nxt = '0;
        end else if (cnt_r == VM2_CNT_W'(RST_DELAY_CYC - 1)) begin
          st_nxt  = VM2_RUN;
          cnt_nxt = '0;
        end
      end
      default: st_nxt = VM2_RUN;
    endcase
    rst_nxt  = (st_nxt != VM2_RUN);
  end

  // registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cfg_r   <= VM2_CFG_RST;
      flag_r  <= 1'b0;
      prev_r  <= 1'b1;  // comparator idles high, no false rise
      rd_r    <= 1'b0;
      rdata_r <= '0;
      irqm_r  <= 1'b0;
      nmi_r   <= 1'b0;
      evt_r   <= 1'b0;
      st_r    <= VM2_RUN;
      cnt_r   <= '0;
      rst_r   <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      flag_r  <= flag_nxt;
      prev_r  <= prev_nxt;
      rd_r    <= rd_nxt;
      rdata_r <= rdata_nxt;
      irqm_r  <= irqm_nxt;
      nmi_r   <= nmi_nxt;
      evt_r   <= evt_nxt;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      rst_r   <= rst_nxt;
    end
  end

  // outputs straight from flops, except waitrequest, which is decoded from avs_read_in and rd_r
  always_comb begin
    avs_readdata_out       = rdata_r;
    avs_waitrequest_out    = avs_read_in & ~rd_r;
    mon2_level_sel_out     = cfg_r.level_sel;
    mon2_input_src_sel_out = cfg_r.input_src_sel;
    mon2_circuit_en_out    = cfg_r.circuit_en;
    irq_maskable_out       = irqm_r;
    irq_nmi_out            = nmi_r;
    event_out              = evt_r;
    mon_rst_out            = rst_r;
  end

endmodule
`default_nettype wire

/* File: tb/vm2_cmp_model.sv */
// Purpose: behavioural threshold comparator for monitor channel 2
// Assumes: voltages are 3-bit codes, threshold is level code plus one
// Notes  : output parks high while the circuit is off, so no false crossing
`timescale 1ns/1ps
`default_nettype none
module vm2_cmp_model (
  input  wire logic [1:0] lvl_in,
  input  wire logic       src_in,
  input  wire logic       en_in,
  input  wire logic [2:0] sup_v_in,
  input  wire logic [2:0] pin_v_in,
  output logic            above_out
);
  // source pick, then compare against the selected level
  assign above_out = !en_in ||
    ((src_in ? pin_v_in : sup_v_in) >= (3'(lvl_in) + 3'h1));
endmodule
`default_nettype wire

/* File: tb/vm2_ctrl_properties.sv */
// Purpose: port-level timing checks of vm2_ctrl
// Assumes: single clock, synchronous active-high reset
// Notes  : bound into every vm2_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module vm2_ctrl_properties #(
  parameter int RST_DELAY_CYC = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic cmp_above_in,
  input wire logic irq_maskable_out,
  input wire logic irq_nmi_out,
  input wire logic event_out,
  input wire logic mon_rst_out
);
  int hi_c;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // cycles of reset held while the input is already back above
  always_ff @(posedge ref_clk_in)
    hi_c <= (rst_in || !mon_rst_out || !cmp_above_in) ? 0 : hi_c + 1;
  a_write_nowait: assert property (
    avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
  a_read_wait: assert property (
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read wait state wrong");
  a_irq_pulse: assert property (
    irq_maskable_out |=> !irq_maskable_out) else $error("irq not a pulse");
  a_irq_excl: assert property (
    !(irq_maskable_out && irq_nmi_out)) else $error("both irq types");
  a_irq_event: assert property (
    irq_maskable_out || irq_nmi_out |-> event_out)
    else $error("irq without event");
  a_event_cause: assert property (
    event_out |-> $past(cmp_above_in, 2) != $past(cmp_above_in) ||
    $past(cmp_above_in) != cmp_above_in) else $error("event no crossing");
  a_rst_cause: assert property (
    $rose(mon_rst_out) |-> !$past(cmp_above_in)) else $error("rst cause");
  a_rst_min: assert property (
    $rose(mon_rst_out) |-> mon_rst_out [*7]) else $error("rst too short");
  a_rst_bound: assert property (
    hi_c <= RST_DELAY_CYC + 3) else $error("rst release late");
  a_rst_noirq: assert property (
    $rose(mon_rst_out) |-> !irq_maskable_out && !irq_nmi_out)
    else $error("irq in reset mode");
  c_nmi: cover property (irq_nmi_out);
  c_maskable: cover property (irq_maskable_out);
  c_rst: cover property ($fell(mon_rst_out));
endmodule
bind vm2_ctrl vm2_ctrl_properties #(.RST_DELAY_CYC(RST_DELAY_CYC)) u_p (.*);
`default_nettype wire

/* File: tb/vm2_ctrl_tb.sv */
// Purpose: self-checking bench of vm2_ctrl
// Assumes: reset delay shortened to DLY cycles
// Notes  : comparator model closes the loop on cmp_above_in
`timescale 1ns/1ps
`default_nettype none
module vm2_ctrl_tb;
  import vm2_pkg::*;
  localparam int DLY = 8;
  localparam logic [4:0] AD [4] = '{5'h00, 5'h04, 5'h08, 5'h0c};
  localparam logic [31:0] MK [4] = '{32'h3, 32'h3, 32'hc5, 32'h7};
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [4:0]  avs_address_in = '0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out, rq;
  logic [1:0]  mon2_level_sel_out;
  logic        avs_waitrequest_out, cmp_above_in, mon2_input_src_sel_out;
  logic        mon2_circuit_en_out, irq_maskable_out, irq_nmi_out;
  logic        event_out, mon_rst_out;
  logic [2:0]  sup_v = 3'h7, pin_v = 3'h7;
  int          miscompares = 0, n_checks = 0, ev_n = 0, im_n = 0, in_n = 0;
  vm2_ctrl #(.RST_DELAY_CYC(DLY)) DUT (.*);
  vm2_cmp_model u_cmp (.lvl_in(mon2_level_sel_out),
    .src_in(mon2_input_src_sel_out), .en_in(mon2_circuit_en_out),
    .sup_v_in(sup_v), .pin_v_in(pin_v), .above_out(cmp_above_in));
  initial forever #5 ref_clk_in = ~ref_clk_in;
  // pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge ref_clk_in) begin
    ev_n += int'(event_out);
    im_n += int'(irq_maskable_out);
    in_n += int'(irq_nmi_out);
  end
  // expected crossings for one fall and one rise
  function automatic int exp_n(int k);
    return (k == 2) ? 2 : (k == 0 || k == 1) ? 1 : 0;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 100) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic r, input logic [4:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge ref_clk_in);
    avs_read_in <= r;
    avs_write_in <= !r;
    avs_address_in <= a;
    avs_writedata_in <= d;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    rq = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    guard(n);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [31:0] e);
    xfer(1'b1, a, 32'h0);
    chk(nm, e, rq);
  endtask
  // move the selected source, then let the crossing settle
  task automatic tog(input logic s, input logic [2:0] v);
    @(posedge ref_clk_in);
    if (s) pin_v <= v;
    else sup_v <= v;
    repeat (6) @(posedge ref_clk_in);
  endtask
  initial begin
    logic [1:0] lv;
    logic s, t;
    int n, ev0, im0, in0;
    void'($urandom(32'h6277));
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rchk("stat_rst", 5'h10, 32'h2);
    xfer(1'b0, 5'h14, '1);
    rchk("unmapped", 5'h14, 32'h0);
    foreach (AD[i]) begin
      xfer(1'b0, AD[i], '1);
      rchk("fields", AD[i], MK[i]);
      xfer(1'b0, AD[i], 32'h0);
    end
    for (int k = 0; k < 5; k++) begin
      lv = 2'($urandom);
      s = 1'($urandom);
      t = 1'($urandom);
      sup_v <= s ? 3'($urandom) : 3'h7;
      pin_v <= s ? 3'h7 : 3'($urandom);
      xfer(1'b0, 5'h00, 32'(lv));
      xfer(1'b0, 5'h04, 32'(s));
      xfer(1'b0, 5'h08, 32'h0);
      xfer(1'b0, 5'h0c, 32'({t, 2'(k)}));
      xfer(1'b0, 5'h04, 32'({1'b1, s}));
      repeat (4) @(posedge ref_clk_in);
      chk("cfg", 32'({lv, s, 1'b1}), 32'({mon2_level_sel_out,
        mon2_input_src_sel_out, mon2_circuit_en_out}));
      xfer(1'b0, 5'h08, 32'h4);
      repeat (200) @(posedge ref_clk_in);
      xfer(1'b0, 5'h10, 32'h0);
      xfer(1'b0, 5'h08, (k < 4) ? 32'h5 : 32'h1);
      // snapshot the running pulse counts, one writer per counter
      ev0 = ev_n;
      im0 = im_n;
      in0 = in_n;
      tog(s, 3'h0);
      tog(s, 3'h7);
      chk("events", exp_n(k), ev_n - ev0);
      chk("irq_m", t ? 0 : exp_n(k), im_n - im0);
      chk("irq_n", t ? exp_n(k) : 0, in_n - in0);
      rchk("flag", 5'h10, (exp_n(k) > 0) ? 32'h3 : 32'h2);
      xfer(1'b0, 5'h10, 32'h0);
      rchk("flag_clr", 5'h10, 32'h2);
      xfer(1'b0, 5'h08, 32'h0);
      xfer(1'b0, 5'h04, 32'h0);
    end
    // supply and pin start above the threshold for the reset runs
    sup_v <= 3'h7;
    pin_v <= 3'h7;
    for (int r = 0; r < 2; r++) begin
      xfer(1'b0, 5'h08, 32'h41 | (32'(r) << 7));
      xfer(1'b0, 5'h04, 32'h2);
      repeat (4) @(posedge ref_clk_in);
      xfer(1'b0, 5'h08, 32'h45 | (32'(r) << 7));
      tog(1'b0, 3'h0);
      if (r == 0) repeat (20) @(posedge ref_clk_in);
      chk("rst_on", 32'h1, 32'(mon_rst_out));
      @(posedge ref_clk_in);
      sup_v <= 3'h7;
      n = 0;
      while (mon_rst_out !== 1'b0 && n < 100) begin
        @(posedge ref_clk_in);
        n++;
      end
      guard(n);
      chk("rst_rel", 32'h1, 32'(r ? (n <= DLY - 3) :
        (n >= DLY && n <= DLY + 3)));
      xfer(1'b0, 5'h08, 32'h0);
      xfer(1'b0, 5'h04, 32'h0);
    end
    // mid-run reset must return the edge register to its reset value
    xfer(1'b0, 5'h0c, 32'h6);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rchk("ctrl1_rst", 5'h0c, 32'h0);
    rchk("stat_rst2", 5'h10, 32'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire
